/* File: tlp_pkg.sv */
// constants, encodings and a helper function for the three-channel led pwm control block
package tlp_pkg;

  // clock and pwm timing
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS = 50;
  localparam int unsigned SLOW_CLK_HZ = 32768;
  localparam int unsigned FAST_PWM_HZ = 558;
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned FAST_DIV = SYS_CLK_HZ / (FAST_PWM_HZ * PWM_STEPS);
  localparam logic [9:0] SLOW_DIV_M1 = 10'(SLOW_DIV - 1);
  localparam logic [7:0] FAST_DIV_M1 = 8'(FAST_DIV - 1);

  // headroom filter: a condition must persist this long to change the gain
  localparam int unsigned FILTER_NS = 1000;
  localparam int unsigned FILTER_CYCLES = (FILTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [4:0] FILTER_M1 = 5'(FILTER_CYCLES - 1);

  // slave address
  localparam logic [3:0] GROUP_ID = 4'h6;
  localparam logic [2:0] STRAP_ADDR_BASE = 3'h2;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h01;
  localparam logic [7:0] REG_RED_PWM = 8'h02;
  localparam logic [7:0] REG_GREEN_PWM = 8'h03;
  localparam logic [7:0] REG_BLUE_PWM = 8'h04;
  localparam logic [7:0] REG_RED_CURRENT = 8'h05;
  localparam logic [7:0] REG_GREEN_CURRENT = 8'h06;
  localparam logic [7:0] REG_BLUE_CURRENT = 8'h07;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int unsigned NUM_RW_REGS = 8;

  // field positions
  localparam int unsigned CTRL_CURVED_BIT = 0;
  localparam int unsigned CTRL_PROG_BIT = 1;
  localparam int unsigned CFG_GAIN_LSB = 0;
  localparam int unsigned CFG_RED_BATT_BIT = 2;
  localparam int unsigned CFG_FAST_BIT = 3;
  localparam int unsigned CFG_EXT_BIT = 4;

  // reset values
  localparam logic [7:0] REG_RST = 8'h00;

  // pump gain select encodings
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_BYPASS = 2'h1;
  localparam logic [1:0] GAIN_BOOST = 2'h2;
  localparam logic [1:0] GAIN_AUTO = 2'h3;

  typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_SUB, LS_WDATA, LS_RDATA} tlp_link_state_t;

  // piecewise-linear curved response
  function automatic logic [7:0] tlp_curve(input logic [7:0] v);
    logic [7:0] r;
    r = {1'b0, v[7:1]};
    if (v[7:6] == 2'h3) begin
      r = {v[6:0], 1'b0} - 8'hFF;
    end else if (v[7]) begin
      r = v - 8'h40;
    end
    return r;
  endfunction : tlp_curve

endpackage : tlp_pkg

/* File: tlp_led_pwm_ctrl.sv */
// three-channel led current, pwm, pump gain and two-wire slave port
`timescale 1ns/100ps
// What this block does
// - pump gain offers off, bypass 1x, boost 1.5x and automatic.
// - automatic mode bypasses while headroom is fine, boosts when any monitored driver lacks it.
// - power save ties the pump output to the supply through a resistor.
// - headroom indications are filtered so short glitches change no gain.
// - red from battery removes red from headroom monitoring; green and blue stay.
// - green and blue always on pump output; red routed by its routing bit.
// - each channel current is an 8-bit code, 0.1 mA per step.
// - duty comes from the program engine or from the channel pwm register.
// - pwm rate is 128 Hz or 558 Hz by the fast-rate bit.
// - one curved-response bit applies to all three channels.
// - with the external clock the pwm rate scales with that clock.
// - curved map: v/2 below 128, v-64 up to 191, 2v-255 above.
// - respond only to address 0110 plus the strap-derived three bits.
// - straps 00,01,10,11 give low address bits 010,011,100,101.
// - on write-address match acknowledge, then take next byte as subaddress.
// - acknowledge each valid address, subaddress and data byte.
// - register address advances after each written or host-acknowledged data byte.
// - a transaction ends on the next start or when the host does not acknowledge a sent data byte; stop only clears frame_open.
// - start is sda falling while scl high; shifting then begins.
// - stop is sda rising while scl high.
// - fast-rate bit picks the internal fast source, else slow or external clock.
module tlp_led_pwm_ctrl
  import tlp_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_strap_low_i,
  input wire logic address_strap_high_i,
  input wire logic slow_clock_input_i,
  input wire logic power_save_i,
  input wire logic [2:0] headroom_low_i,
  input wire logic [7:0] engine_red_duty_i,
  input wire logic [7:0] engine_green_duty_i,
  input wire logic [7:0] engine_blue_duty_i,
  output logic [7:0] red_current_o,
  output logic [7:0] green_current_o,
  output logic [7:0] blue_current_o,
  output logic red_pwm_o,
  output logic green_pwm_o,
  output logic blue_pwm_o,
  output logic pump_off_pulldown_o,
  output logic pump_bypass_o,
  output logic pump_boost_o,
  output logic pump_save_tie_o,
  output logic red_from_vout_o,
  output logic red_from_battery_o
);

  // ---------------- system domain: pin synchronisers ----------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [1:0] strap_m, strap_s;
  logic ext_m, ext_s, ext_d;
  logic psave_m, psave_s;
  logic [2:0] hr_m, hr_s;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      strap_m <= 2'h0;
      strap_s <= 2'h0;
      ext_m <= 1'b0;
      ext_s <= 1'b0;
      ext_d <= 1'b0;
      psave_m <= 1'b0;
      psave_s <= 1'b0;
      hr_m <= 3'h0;
      hr_s <= 3'h0;
    end else begin
      strap_m <= {address_strap_high_i, address_strap_low_i};
      strap_s <= strap_m;
      ext_m <= slow_clock_input_i;
      ext_s <= ext_m;
      ext_d <= ext_s;
      psave_m <= power_save_i;
      psave_s <= psave_m;
      hr_m <= headroom_low_i;
      hr_s <= hr_m;
    end
  end

  // ---------------- start / stop detection ----------------
  logic start_evt, stop_evt;
  logic start_tgl, frame_open;

  assign start_evt = scl_s && scl_d && sda_d && !sda_s;
  assign stop_evt = scl_s && scl_d && !sda_d && sda_s;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      start_tgl <= 1'b0;
      frame_open <= 1'b0;
    end else if (start_evt) begin
      start_tgl <= ~start_tgl;
      frame_open <= 1'b1;
    end else if (stop_evt) begin
      frame_open <= 1'b0;
    end
  end

  // strap level followed continuously; strap_done marks the first valid sample
  logic strap_done;
  logic [2:0] dev_addr;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      strap_done <= 1'b0;
      dev_addr <= STRAP_ADDR_BASE;
    end else begin
      strap_done <= 1'b1;
      dev_addr <= {1'b0, strap_s} + STRAP_ADDR_BASE;
    end
  end

  // ---------------- link domain (scl clock) ----------------
  logic link_rst_m, link_rst;
  logic start_n1, start_n2, start_seen;
  logic [2:0] dev_addr_m, dev_addr_l;
  logic [7:0] status_m, status_l;
  logic [7:0] status_byte;
  tlp_link_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg, regptr, rd_byte;
  logic [7:0] rx_byte;
  logic ack_en, wr_tgl;
  logic [7:0] link_regs [NUM_RW_REGS];

  always_ff @(posedge scl_i) begin
    link_rst_m <= srst_i;
    link_rst <= link_rst_m;
    dev_addr_m <= dev_addr;
    dev_addr_l <= dev_addr_m;
    status_m <= status_byte;
    status_l <= status_m;
    start_n2 <= start_n1;
    shreg <= {shreg[6:0], sda_i};
  end

  // start toggle: first stage on the falling edge, second on the rising edge
  always_ff @(negedge scl_i) begin
    start_n1 <= start_tgl;
  end

  assign rx_byte = {shreg[6:0], sda_i};

  always_ff @(posedge scl_i) begin
    if (link_rst) begin
      state <= LS_IDLE;
      bitcnt <= 4'h0;
      ack_en <= 1'b0;
      regptr <= 8'h00;
      wr_tgl <= 1'b0;
      start_seen <= start_n2;
      for (int i = 0; i < NUM_RW_REGS; i++) begin
        link_regs[i] <= REG_RST;
      end
    end else if (start_n2 != start_seen) begin
      // the edge before this one already carried the first address bit
      start_seen <= start_n2;
      state <= LS_ADDR;
      bitcnt <= 4'h2;
      ack_en <= 1'b0;
    end else if (state != LS_IDLE) begin
      if (bitcnt == 4'h8) begin
        bitcnt <= 4'h0;
        ack_en <= 1'b0;
        if (state == LS_RDATA && !ack_en) begin
          if (sda_i) begin
            state <= LS_IDLE;
          end else begin
            regptr <= regptr + 8'h01;
          end
        end
      end else begin
        bitcnt <= bitcnt + 4'h1;
        if (bitcnt == 4'h7) begin
          case (state)
            LS_ADDR: begin
              if (rx_byte[7:1] == {GROUP_ID, dev_addr_l}) begin
                ack_en <= 1'b1;
                state <= rx_byte[0] ? LS_RDATA : LS_SUB;
              end else begin
                state <= LS_IDLE;
              end
            end
            LS_SUB: begin
              regptr <= rx_byte;
              ack_en <= 1'b1;
              state <= LS_WDATA;
            end
            LS_WDATA: begin
              ack_en <= 1'b1;
              regptr <= regptr + 8'h01;
              if (regptr < REG_STATUS) begin
                link_regs[regptr[2:0]] <= rx_byte;
                wr_tgl <= ~wr_tgl;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (regptr < REG_STATUS) begin
      rd_byte = link_regs[regptr[2:0]];
    end else if (regptr == REG_STATUS) begin
      rd_byte = status_l;
    end
  end

  // sda changes only on the falling scl edge
  always_ff @(negedge scl_i) begin
    if (link_rst) begin
      sda_oe_o <= 1'b0;
    end else if (bitcnt == 4'h8) begin
      sda_oe_o <= ack_en;
    end else if (state == LS_RDATA) begin
      sda_oe_o <= !rd_byte[3'h7 - bitcnt[2:0]];
    end else begin
      sda_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    sda_o <= 1'b0;
  end

  // ---------------- register shadow in the system domain ----------------
  logic wr_m, wr_s, wr_d;
  logic [7:0] sh_regs [NUM_RW_REGS];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_m <= 1'b0;
      wr_s <= 1'b0;
      wr_d <= 1'b0;
    end else begin
      wr_m <= wr_tgl;
      wr_s <= wr_m;
      wr_d <= wr_s;
    end
  end

  // the link words are stable for many scl periods after each toggle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_RW_REGS; i++) begin
        sh_regs[i] <= REG_RST;
      end
    end else if (wr_s != wr_d) begin
      for (int i = 0; i < NUM_RW_REGS; i++) begin
        sh_regs[i] <= link_regs[i];
      end
    end
  end

  logic curved, prog_duty, red_batt, fast_rate, ext_sel;
  logic [1:0] gain_sel;

  assign curved = sh_regs[REG_CTRL[2:0]][CTRL_CURVED_BIT];
  assign prog_duty = sh_regs[REG_CTRL[2:0]][CTRL_PROG_BIT];
  assign gain_sel = sh_regs[REG_CONFIG[2:0]][CFG_GAIN_LSB +: 2];
  assign red_batt = sh_regs[REG_CONFIG[2:0]][CFG_RED_BATT_BIT];
  assign fast_rate = sh_regs[REG_CONFIG[2:0]][CFG_FAST_BIT];
  assign ext_sel = sh_regs[REG_CONFIG[2:0]][CFG_EXT_BIT];

  assign red_current_o = sh_regs[REG_RED_CURRENT[2:0]];
  assign green_current_o = sh_regs[REG_GREEN_CURRENT[2:0]];
  assign blue_current_o = sh_regs[REG_BLUE_CURRENT[2:0]];

  // ---------------- pwm step sources ----------------
  logic [9:0] slow_cnt;
  logic [7:0] fast_cnt;
  logic slow_tick, fast_tick, ext_tick, pwm_step;
  logic [7:0] pwm_cnt;

  assign slow_tick = (slow_cnt == SLOW_DIV_M1);
  assign fast_tick = (fast_cnt == FAST_DIV_M1);
  assign ext_tick = ext_s && !ext_d;

  always_ff @(posedge clock_i) begin
    if (srst_i || slow_tick) begin
      slow_cnt <= 10'h000;
    end else begin
      slow_cnt <= slow_cnt + 10'h001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || fast_tick) begin
      fast_cnt <= 8'h00;
    end else begin
      fast_cnt <= fast_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwm_step <= 1'b0;
    end else if (fast_rate) begin
      pwm_step <= fast_tick;
    end else begin
      pwm_step <= ext_sel ? ext_tick : slow_tick;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwm_cnt <= 8'h00;
    end else if (pwm_step) begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // ---------------- per-channel pwm ----------------
  logic [7:0] eng_duty [3];
  logic [7:0] eff_duty [3];
  logic [2:0] pwm_q;

  assign eng_duty[0] = engine_red_duty_i;
  assign eng_duty[1] = engine_green_duty_i;
  assign eng_duty[2] = engine_blue_duty_i;

  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    logic [7:0] src;
    assign src = prog_duty ? eng_duty[ch] : sh_regs[REG_RED_PWM[2:0] + 3'(ch)];
    assign eff_duty[ch] = curved ? tlp_curve(src) : src;
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        pwm_q[ch] <= 1'b0;
      end else begin
        pwm_q[ch] <= (pwm_cnt < eff_duty[ch]);
      end
    end
  end

  assign red_pwm_o = pwm_q[0];
  assign green_pwm_o = pwm_q[1];
  assign blue_pwm_o = pwm_q[2];

  // ---------------- automatic gain and pump control ----------------
  logic mon_lack, lack_f;
  logic [4:0] flt_cnt;

  assign mon_lack = |(hr_s & {2'b11, !red_batt});

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lack_f <= 1'b0;
      flt_cnt <= 5'h00;
    end else if (mon_lack == lack_f) begin
      flt_cnt <= 5'h00;
    end else if (flt_cnt == FILTER_M1) begin
      lack_f <= mon_lack;
      flt_cnt <= 5'h00;
    end else begin
      flt_cnt <= flt_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pump_off_pulldown_o <= 1'b1;
      pump_bypass_o <= 1'b0;
      pump_boost_o <= 1'b0;
      pump_save_tie_o <= 1'b0;
    end else if (psave_s) begin
      pump_off_pulldown_o <= 1'b0;
      pump_bypass_o <= 1'b0;
      pump_boost_o <= 1'b0;
      pump_save_tie_o <= 1'b1;
    end else begin
      pump_save_tie_o <= 1'b0;
      case (gain_sel)
        GAIN_OFF: begin
          pump_off_pulldown_o <= 1'b1;
          pump_bypass_o <= 1'b0;
          pump_boost_o <= 1'b0;
        end
        GAIN_BYPASS: begin
          pump_off_pulldown_o <= 1'b0;
          pump_bypass_o <= 1'b1;
          pump_boost_o <= 1'b0;
        end
        GAIN_BOOST: begin
          pump_off_pulldown_o <= 1'b0;
          pump_bypass_o <= 1'b0;
          pump_boost_o <= 1'b1;
        end
        default: begin
          pump_off_pulldown_o <= 1'b0;
          pump_bypass_o <= !lack_f;
          pump_boost_o <= lack_f;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      red_from_battery_o <= 1'b0;
      red_from_vout_o <= 1'b1;
    end else begin
      red_from_battery_o <= red_batt;
      red_from_vout_o <= !red_batt;
    end
  end

  assign status_byte = {3'h0, frame_open, lack_f, pump_save_tie_o, pump_boost_o, pump_bypass_o};

  // ---------------- checks ----------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_auto_lack;
    gain_sel == GAIN_AUTO && !psave_s && lack_f;
  endsequence

  sequence s_batt_sel;
    red_batt ##1 red_batt;
  endsequence

  chk_gain_boost: assert property (
    (gain_sel == GAIN_BOOST && !psave_s) |=> (pump_boost_o && !pump_bypass_o))
    else $error("manual boost not applied");

  chk_auto_switch: assert property (
    s_auto_lack |=> (pump_boost_o && !pump_bypass_o))
    else $error("automatic gain did not boost");

  chk_filter_len: assert property (
    $changed(lack_f) |-> ($past(flt_cnt) == FILTER_M1 && $past(mon_lack) == lack_f))
    else $error("headroom filter changed early");

  chk_save_tie: assert property (
    psave_s |=> (pump_save_tie_o && !pump_boost_o && !pump_bypass_o))
    else $error("power save tie missing");

  chk_red_mask: assert property (
    (red_batt && hr_s == 3'h1) |-> !mon_lack)
    else $error("red monitored while on battery");

  chk_red_route: assert property (
    s_batt_sel |-> (red_from_battery_o && !red_from_vout_o))
    else $error("red supply routing wrong");

  chk_curve_top: assert property (
    (curved && eff_duty[0] != 8'h00 && g_chan[0].src[7:6] == 2'h3)
      |-> (eff_duty[0] == {g_chan[0].src[6:0], 1'b0} - 8'hFF))
    else $error("curved map wrong above 191");

  chk_pwm_zero: assert property (
    (eff_duty[1] == 8'h00) |=> !green_pwm_o)
    else $error("zero duty still drives pwm");

  chk_strap_addr: assert property (
    (!strap_done ##1 strap_done) |-> (dev_addr == {1'b0, $past(strap_s)} + STRAP_ADDR_BASE))
    else $error("strap address mismatch");

endmodule : tlp_led_pwm_ctrl

/* File: tlp_host_model.sv */
// two-wire bus controller model that drives the link clock and data
`timescale 1ns/100ps
module tlp_host_model (
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  localparam int H = 1250;
  localparam int Q = 300;

  // scl idles high between frames; sda is released to the pull-up
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // short scl pulses with sda high so the link registers see reset
  task automatic rst_pulses();
    repeat (3) begin
      #100 scl_o = 1'b0;
      #100 scl_o = 1'b1;
    end
  endtask : rst_pulses

  // sda moves a quarter into the low phase, sampled at the end of high
  task automatic bit_io(input logic b, output logic s);
    scl_o = 1'b0;
    #Q pull_o = ~b;
    #(H - Q) scl_o = 1'b1;
    #H s = sda_i;
  endtask : bit_io

  task automatic start();
    scl_o = 1'b0;
    #Q pull_o = 1'b0;
    #(H - Q) scl_o = 1'b1;
    #H pull_o = 1'b1;
    #H;
  endtask : start

  task automatic stop();
    scl_o = 1'b0;
    #Q pull_o = 1'b1;
    #(H - Q) scl_o = 1'b1;
    #H pull_o = 1'b0;
    #(2 * H);
  endtask : stop

  // ack_in is the level put on the ninth bit; ack is the device's answer
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(ack_in, s);
    ack = ~s;
  endtask : xfer
endmodule : tlp_host_model

/* File: tlp_led_pwm_ctrl_bench.sv */
// self-checking bench for the three-channel led pwm control block
`timescale 1ns/100ps
module tlp_led_pwm_ctrl_bench;
  import tlp_pkg::*;

  typedef struct packed {
    logic [7:0] sub, data, r, g, b;
    logic [3:0] pump;
    logic [1:0] route;
  } tlp_row_t;

  logic clk, srst = 1'b1, scl, pull, sda_o, sda_oe;
  logic slow = 1'b0, psave = 1'b0, st_lo = 1'b0, st_hi = 1'b0;
  logic [2:0] hr = 3'h0;
  logic [7:0] er = 8'h00, eg = 8'h00, eb = 8'h00;
  logic [2:0] dev = STRAP_ADDR_BASE;
  wire [7:0] cr, cg, cb;
  wire [3:0] pump;
  wire [1:0] route;
  wire [2:0] pwm;
  wire sda = ~(pull | (sda_oe & ~sda_o));
  int failures = 0;
  int compares = 0;
  int nr, ng, nb;

  tlp_row_t rows [8] = '{
    '{8'h05, 8'hFF, 8'hFF, 8'h00, 8'h00, 4'h8, 2'h2},
    '{8'h06, 8'hAF, 8'hFF, 8'hAF, 8'h00, 4'h8, 2'h2},
    '{8'h07, 8'h01, 8'hFF, 8'hAF, 8'h01, 4'h8, 2'h2},
    '{8'h01, 8'h01, 8'hFF, 8'hAF, 8'h01, 4'h4, 2'h2},
    '{8'h01, 8'h02, 8'hFF, 8'hAF, 8'h01, 4'h2, 2'h2},
    '{8'h01, 8'h06, 8'hFF, 8'hAF, 8'h01, 4'h2, 2'h1},
    '{8'h01, 8'h00, 8'hFF, 8'hAF, 8'h01, 4'h8, 2'h2},
    '{8'h07, 8'h00, 8'hFF, 8'hAF, 8'h00, 4'h8, 2'h2}
  };

  tlp_host_model tlp_host_model_inst (.scl_o(scl), .pull_o(pull), .sda_i(sda));

  tlp_led_pwm_ctrl tlp_led_pwm_ctrl_inst (
    .clock_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .address_strap_low_i(st_lo), .address_strap_high_i(st_hi),
    .slow_clock_input_i(slow), .power_save_i(psave), .headroom_low_i(hr),
    .engine_red_duty_i(er), .engine_green_duty_i(eg), .engine_blue_duty_i(eb),
    .red_current_o(cr), .green_current_o(cg), .blue_current_o(cb),
    .red_pwm_o(pwm[0]), .green_pwm_o(pwm[1]), .blue_pwm_o(pwm[2]),
    .pump_off_pulldown_o(pump[3]), .pump_bypass_o(pump[2]), .pump_boost_o(pump[1]),
    .pump_save_tie_o(pump[0]), .red_from_vout_o(route[1]), .red_from_battery_o(route[0])
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // external slow clock: one pwm step every 8 system clocks
  always begin
    repeat (4) @(negedge clk);
    slow = ~slow;
  end

  task automatic check_bits(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check_bits

  task automatic check_near(input string n, input int e, input int g, input int tol);
    compares++;
    if (g < e - tol || g > e + tol) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask : check_near

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [6:0] a, input logic [7:0] sub, input int n,
                    input logic [23:0] d, input logic exp_ack);
    logic [7:0] q;
    logic ack;
    tlp_host_model_inst.start();
    tlp_host_model_inst.xfer({a, 1'b0}, 1'b1, q, ack);
    check_bits("address ack", 8'(exp_ack), 8'(ack));
    if (ack) begin
      tlp_host_model_inst.xfer(sub, 1'b1, q, ack);
      check_bits("subaddress ack", 8'h01, 8'(ack));
      for (int i = 0; i < n; i++) begin
        tlp_host_model_inst.xfer(d[23 - 8 * i -: 8], 1'b1, q, ack);
        check_bits("data ack", 8'h01, 8'(ack));
      end
    end
    tlp_host_model_inst.stop();
    repeat (10) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] sub, input int n, input logic [23:0] e);
    logic [7:0] q;
    logic ack;
    tlp_host_model_inst.start();
    tlp_host_model_inst.xfer({GROUP_ID, dev, 1'b0}, 1'b1, q, ack);
    tlp_host_model_inst.xfer(sub, 1'b1, q, ack);
    tlp_host_model_inst.start();
    tlp_host_model_inst.xfer({GROUP_ID, dev, 1'b1}, 1'b1, q, ack);
    check_bits("read address ack", 8'h01, 8'(ack));
    for (int i = 0; i < n; i++) begin
      tlp_host_model_inst.xfer(8'hFF, (i == n - 1), q, ack);
      check_bits("read data", e[23 - 8 * i -: 8], q);
    end
    tlp_host_model_inst.stop();
  endtask : rd

  task automatic gain_step(input logic [2:0] v, input int hold, input logic [3:0] e);
    @(negedge clk) hr = v;
    repeat (hold) @(negedge clk);
    if (hold < 20) begin
      hr = 3'h0;
    end
    repeat (30) @(negedge clk);
    check_bits("auto gain", {4'h0, e}, {4'h0, pump});
  endtask : gain_step

  task automatic count(input int span);
    nr = 0;
    ng = 0;
    nb = 0;
    repeat (span) @(negedge clk) begin
      nr += int'(pwm[0]);
      ng += int'(pwm[1]);
      nb += int'(pwm[2]);
    end
  endtask : count

  initial begin
    #5_500_000;
    failures++;
    end_sim();
  end

  initial begin
    @(negedge clk);
    fork
      tlp_host_model_inst.rst_pulses();
      repeat (12) @(negedge clk);
    join
    srst = 1'b0;
    repeat (6) @(negedge clk);
    // flush the released reset through the link-side synchroniser before any frame
    tlp_host_model_inst.rst_pulses();
    check_bits("reset currents", 8'h00, cr | cg | cb);
    check_bits("reset pump", 8'h08, {4'h0, pump});
    check_bits("reset route", 8'h02, {6'h0, route});
    check_bits("reset pwm sda", 8'h00, {4'h0, pwm, sda_oe});
    foreach (rows[i]) begin
      wr({GROUP_ID, dev}, rows[i].sub, 1, {rows[i].data, 16'h0}, 1'b1);
      check_bits("red current", rows[i].r, cr);
      check_bits("green current", rows[i].g, cg);
      check_bits("blue current", rows[i].b, cb);
      check_bits("pump mode", {4'h0, rows[i].pump}, {4'h0, pump});
      check_bits("red route", {6'h0, rows[i].route}, {6'h0, route});
    end
    for (int s = 0; s < 4; s++) begin
      @(negedge clk) {st_hi, st_lo} = 2'(s);
      dev = STRAP_ADDR_BASE + 3'(s);
      repeat (6) @(negedge clk);
      wr({GROUP_ID, dev}, 8'h05, 1, {8'h10 + 8'(s), 16'h0}, 1'b1);
      wr({GROUP_ID, dev + 3'h1}, 8'h05, 1, 24'hEE0000, 1'b0);
      wr({4'h7, dev}, 8'h05, 1, 24'hEE0000, 1'b0);
      check_bits("strap current", 8'h10 + 8'(s), cr);
    end
    wr({GROUP_ID, dev}, 8'h05, 3, 24'h112233, 1'b1);
    check_bits("burst", 8'h33, cb);
    rd(8'h05, 3, 24'h112233);
    wr({GROUP_ID, dev}, 8'h20, 1, 24'h5A0000, 1'b1);
    rd(8'h20, 1, 24'h000000);
    wr({GROUP_ID, dev}, 8'h01, 1, {6'h0, GAIN_AUTO, 16'h0}, 1'b1);
    gain_step(3'h0, 40, 4'h4);
    gain_step(3'h1, 40, 4'h2);
    gain_step(3'h0, 40, 4'h4);
    gain_step(3'h2, 15, 4'h4);
    wr({GROUP_ID, dev}, 8'h01, 1, {5'h0, 1'b1, GAIN_AUTO, 16'h0}, 1'b1);
    gain_step(3'h1, 40, 4'h4);
    gain_step(3'h4, 40, 4'h2);
    @(negedge clk) psave = 1'b1;
    repeat (8) @(negedge clk);
    check_bits("power save", 8'h01, {4'h0, pump});
    psave = 1'b0;
    hr = 3'h0;
    wr({GROUP_ID, dev}, 8'h02, 3, 24'hC8C840, 1'b1);
    wr({GROUP_ID, dev}, 8'h01, 1, 24'h100000, 1'b1);
    wr({GROUP_ID, dev}, 8'h00, 1, 24'h000000, 1'b1);
    count(2048);
    check_near("linear red", 200 * 8, nr, 16);
    check_near("linear blue", 64 * 8, nb, 16);
    wr({GROUP_ID, dev}, 8'h00, 1, 24'h010000, 1'b1);
    count(2048);
    check_near("curved red", (2 * 200 - 255) * 8, nr, 16);
    check_near("curved green", (2 * 200 - 255) * 8, ng, 16);
    check_near("curved blue", (64 / 2) * 8, nb, 16);
    @(negedge clk) {er, eg, eb} = 24'h3000FF;
    wr({GROUP_ID, dev}, 8'h00, 1, 24'h020000, 1'b1);
    count(2048);
    check_near("engine red", 48 * 8, nr, 16);
    check_near("engine blue", 255 * 8, nb, 16);
    wr({GROUP_ID, dev}, 8'h00, 1, 24'h000000, 1'b1);
    wr({GROUP_ID, dev}, 8'h01, 1, 24'h080000, 1'b1);
    count(256 * FAST_DIV);
    check_near("fast red", 200 * FAST_DIV, nr, 2 * FAST_DIV);
    check_near("fast blue", 64 * FAST_DIV, nb, 2 * FAST_DIV);
    end_sim();
  end
endmodule : tlp_led_pwm_ctrl_bench
